// ### shared/swei_pkg.sv
package swei_pkg;

   localparam int OPC_BITS  = 8;
   localparam int ADDR_BITS = 8;
   localparam int DATA_BITS = 16;
   localparam int WORDS     = 256;

   localparam logic [7:0] OPC_WRITE = 8'hA4;
   localparam logic [7:0] OPC_READ  = 8'hA8;
   localparam logic [7:0] OPC_WRITE_ENABLE_CMD  = 8'hA3;
   localparam logic [7:0] OPC_WRITE_DISABLE_CMD = 8'hA0;
   // Factory-only fill code, never acted on
   localparam logic [7:0] OPC_FILL  = 8'hAF;

   // Received-bit count after which each field is complete
   localparam logic [5:0] CNT_OPC_LAST  = 6'h07;
   localparam logic [5:0] CNT_ADDR_LAST = 6'h0F;
   localparam logic [5:0] CNT_ADDR_DONE = 6'h10;
   localparam logic [5:0] CNT_DATA_LAST = 6'h1F;
   localparam logic [5:0] CNT_FULL      = 6'h20;
   localparam logic [5:0] FRAME_SHORT   = 6'h10;
   localparam logic [5:0] FRAME_LONG    = 6'h20;
   localparam logic [3:0] WORD_LAST_BIT = 4'hF;

   localparam logic [15:0] ERASED_WORD = 16'hFFFF;

   localparam int SYS_PERIOD_NS = 50;
   localparam int PROG_TIME_NS  = 10_000_000;
   localparam int PROG_CYCLES   = PROG_TIME_NS / SYS_PERIOD_NS;
   localparam int DESEL_NS      = 250;
   localparam int DESEL_CYCLES  = (DESEL_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int HALF_NS       = 250;
   localparam int HALF_CYCLES   = (HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

   typedef enum logic [2:0] {
      SWEI_CMD_READ,
      SWEI_CMD_WRITE,
      SWEI_CMD_WRITE_ENABLE,
      SWEI_CMD_WRITE_DISABLE,
      SWEI_CMD_STATUS
   } swei_cmd_t;

endpackage

// ### shared/swei_link_if.sv
`timescale 1ns/1ps
interface swei_link_if;
   logic selectN;
   logic serialClkN;
   logic serialIn;
   logic serialOut;
   logic serialOutEn;
   logic writeProtect;
   logic serialLine;

   // Output line has a pull-up when the device releases it
   assign serialLine = serialOutEn ? serialOut : 1'b1;

   modport device (
      input  selectN,
      input  serialClkN,
      input  serialIn,
      input  writeProtect,
      output serialOut,
      output serialOutEn
   );

   modport host (
      output selectN,
      output serialClkN,
      output serialIn,
      output writeProtect,
      input  serialLine
   );
endinterface

// ### rtl/swei_device.sv
`timescale 1ns/1ps
module swei_device #(
   parameter int PROG_CYC = swei_pkg::PROG_CYCLES
) (
   input  wire logic         sys_clk,
   input  wire logic         srst,
   swei_link_if.device       lk,
   output logic              progBusy
);

   logic [15:0] mem [swei_pkg::WORDS];

   // Serial-side state
   logic        linkClr;
   logic        selClk_q;
   logic        started_q;
   logic [5:0]  cnt_q;
   logic [31:0] sr_q;
   logic [7:0]  opc_q;
   logic [7:0]  adr_q;
   logic        protMeta_q;
   logic        protSync_q;
   logic        protHit_q;
   logic        doneMeta_q;
   logic        doneSync_q;
   logic        wen_q;
   logic        wrTgl_q;
   logic [7:0]  wrAddr_q;
   logic [15:0] wrData_q;
   logic        rdOn_q;
   logic [3:0]  rdBit_q;
   logic [7:0]  rdAddr_q;
   logic [15:0] outSh_q;
   logic        busyLink;
   logic        statusOn;
   logic        busyAny;

   // System-side state
   logic        reqMeta_q;
   logic        reqSync_q;
   logic        protMetaS_q;
   logic        protSyncS_q;
   logic        doneTgl_q;
   logic [17:0] timer_q;
   logic        pending;
   logic        progEnd;
   logic        commit;

   // Select high clears bit reception, capture, protect and read output asynchronously, since the clock may be stopped
   assign linkClr = lk.selectN | srst;

   // Clock level seen when select falls picks instruction or status mode
   always_ff @(negedge lk.selectN) begin
      selClk_q <= lk.serialClkN;
   end

   assign statusOn = ~lk.selectN & ~selClk_q & ~started_q;

   // Busy is an XOR of two toggles; only one side moves at a time, so no glitch
   assign busyAny = wrTgl_q ^ doneTgl_q;
   assign busyLink = wrTgl_q ^ doneSync_q;

   // Bit reception; leading 1 of the op-code starts the count
   always_ff @(posedge lk.serialClkN or posedge linkClr) begin
      if (linkClr) begin
         started_q <= 1'b0;
         cnt_q     <= 6'h00;
         sr_q      <= 32'h0000_0000;
      end else if (!started_q) begin
         if (lk.serialIn) begin
            started_q <= 1'b1;
            cnt_q     <= 6'h01;
            sr_q      <= 32'h0000_0001;
         end
      end else if (cnt_q != swei_pkg::CNT_FULL) begin
         cnt_q <= cnt_q + 6'h01;
         sr_q  <= {sr_q[30:0], lk.serialIn};
      end
   end

   // Op-code and address capture
   always_ff @(posedge lk.serialClkN or posedge linkClr) begin
      if (linkClr) begin
         opc_q <= 8'h00;
         adr_q <= 8'h00;
      end else if (started_q && cnt_q == swei_pkg::CNT_OPC_LAST) begin
         opc_q <= {sr_q[6:0], lk.serialIn};
      end else if (started_q && cnt_q == swei_pkg::CNT_ADDR_LAST) begin
         adr_q <= {sr_q[6:0], lk.serialIn};
      end
   end

   // Protect pin: two stages, then sticky for the whole instruction
   always_ff @(posedge lk.serialClkN or posedge linkClr) begin
      if (linkClr) begin
         protMeta_q <= 1'b0;
         protSync_q <= 1'b0;
         protHit_q  <= 1'b0;
      end else begin
         protMeta_q <= lk.writeProtect;
         protSync_q <= protMeta_q;
         if (protSync_q) begin
            protHit_q <= 1'b1;
         end
      end
   end

   // Completion toggle brought into the serial domain
   always_ff @(posedge lk.serialClkN or posedge srst) begin
      if (srst) begin
         doneMeta_q <= 1'b0;
         doneSync_q <= 1'b0;
      end else begin
         doneMeta_q <= doneTgl_q;
         doneSync_q <= doneMeta_q;
      end
   end

   // Enable latch and write launch; survive select changes
   always_ff @(posedge lk.serialClkN or posedge srst) begin
      if (srst) begin
         wen_q    <= 1'b0;
         wrTgl_q  <= 1'b0;
         wrAddr_q <= 8'h00;
         wrData_q <= 16'h0000;
      end else if (!lk.selectN && started_q) begin
         if (cnt_q == swei_pkg::CNT_ADDR_LAST) begin
            // Address bits are don't-care for these two
            if ({sr_q[14:7]} == swei_pkg::OPC_WRITE_ENABLE_CMD) begin
               wen_q <= 1'b1;
            end else if ({sr_q[14:7]} == swei_pkg::OPC_WRITE_DISABLE_CMD) begin
               wen_q <= 1'b0;
            end
         end else if (cnt_q == swei_pkg::CNT_DATA_LAST && opc_q == swei_pkg::OPC_WRITE
                      && wen_q && !protHit_q && !protSync_q && !busyLink) begin
            wrAddr_q <= adr_q;
            wrData_q <= {sr_q[14:0], lk.serialIn};
            wrTgl_q  <= ~wrTgl_q;
         end
      end
   end

   // Read output on falling edges; fill-all and others never start it
   always_ff @(negedge lk.serialClkN or posedge linkClr) begin
      if (linkClr) begin
         rdOn_q   <= 1'b0;
         rdBit_q  <= 4'h0;
         rdAddr_q <= 8'h00;
         outSh_q  <= 16'h0000;
      end else if (!rdOn_q) begin
         if (cnt_q == swei_pkg::CNT_ADDR_DONE && opc_q == swei_pkg::OPC_READ) begin
            rdOn_q   <= 1'b1;
            outSh_q  <= mem[adr_q];
            rdAddr_q <= adr_q + 8'h01;
            rdBit_q  <= 4'h0;
         end
      end else if (rdBit_q == swei_pkg::WORD_LAST_BIT) begin
         outSh_q  <= mem[rdAddr_q];
         rdAddr_q <= rdAddr_q + 8'h01;
         rdBit_q  <= 4'h0;
      end else begin
         outSh_q <= {outSh_q[14:0], 1'b0};
         rdBit_q <= rdBit_q + 4'h1;
      end
   end

   // Status follows busy with no serial clock needed
   assign lk.serialOut   = statusOn ? ~busyAny : outSh_q[15];
   assign lk.serialOutEn = statusOn | (rdOn_q & ~lk.selectN);

   // System side: catch write request and protect level
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reqMeta_q   <= 1'b0;
         reqSync_q   <= 1'b0;
         protMetaS_q <= 1'b0;
         protSyncS_q <= 1'b0;
      end else begin
         reqMeta_q   <= wrTgl_q;
         reqSync_q   <= reqMeta_q;
         protMetaS_q <= lk.writeProtect;
         protSyncS_q <= protMetaS_q;
      end
   end

   assign pending = reqSync_q ^ doneTgl_q;
   assign progEnd = timer_q == 18'(PROG_CYC - 1);
   assign commit  = pending & (protSyncS_q | progEnd);

   // Self-timed programming, independent of select and serial clock
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         timer_q   <= 18'h00000;
         doneTgl_q <= 1'b0;
      end else if (pending) begin
         if (commit) begin
            timer_q   <= 18'h00000;
            doneTgl_q <= ~doneTgl_q;
         end else begin
            timer_q <= timer_q + 18'h00001;
         end
      end
   end

   // Aborted word is left erased: contents not guaranteed
   always_ff @(posedge sys_clk) begin
      if (commit) begin
         mem[wrAddr_q] <= protSyncS_q ? swei_pkg::ERASED_WORD : wrData_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         progBusy <= 1'b0;
      end else begin
         progBusy <= pending & ~commit;
      end
   end

endmodule

// ### rtl/swei_host.sv
`timescale 1ns/1ps
module swei_host #(
   parameter int HALF = swei_pkg::HALF_CYCLES,
   parameter int GAP  = swei_pkg::DESEL_CYCLES
) (
   input  wire logic               sys_clk,
   input  wire logic               srst,
   swei_link_if.host               lk,
   input  wire logic               cmdValid,
   input  wire swei_pkg::swei_cmd_t cmdKind,
   input  wire logic [7:0]         cmdAddr,
   input  wire logic [15:0]        cmdData,
   input  wire logic               protectIn,
   output logic                    cmdReady,
   output logic                    rspValid,
   output logic [15:0]             rspData
);

   typedef enum {H_IDLE, H_SHIFT, H_STAT, H_GAP} swei_hstate_t;

   swei_hstate_t        state_q;
   swei_pkg::swei_cmd_t kind_q;
   logic [4:0]          ph_q;
   logic [5:0]          bitCnt_q;
   logic [5:0]          nBits_q;
   logic [31:0]         tx_q;
   logic [15:0]         rx_q;
   logic                selN_q;
   logic                sclk_q;
   logic                din_q;
   logic                prot_q;
   logic                doMeta_q;
   logic                doSync_q;
   logic [7:0]          opSel;

   assign lk.selectN      = selN_q;
   assign lk.serialClkN   = sclk_q;
   assign lk.serialIn     = din_q;
   assign lk.writeProtect = prot_q;

   // No command maps to the factory fill code
   always_comb begin
      case (cmdKind)
         swei_pkg::SWEI_CMD_WRITE: opSel = swei_pkg::OPC_WRITE;
         swei_pkg::SWEI_CMD_READ:  opSel = swei_pkg::OPC_READ;
         swei_pkg::SWEI_CMD_WRITE_ENABLE: opSel = swei_pkg::OPC_WRITE_ENABLE_CMD;
         default:                         opSel = swei_pkg::OPC_WRITE_DISABLE_CMD;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         doMeta_q <= 1'b1;
         doSync_q <= 1'b1;
         prot_q   <= 1'b0;
      end else begin
         doMeta_q <= lk.serialLine;
         doSync_q <= doMeta_q;
         prot_q   <= protectIn;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_q  <= H_IDLE;
         kind_q   <= swei_pkg::SWEI_CMD_READ;
         ph_q     <= 5'h00;
         bitCnt_q <= 6'h00;
         nBits_q  <= 6'h00;
         tx_q     <= 32'h0000_0000;
         rx_q     <= 16'h0000;
         selN_q   <= 1'b1;
         sclk_q   <= 1'b1;
         din_q    <= 1'b0;
         cmdReady <= 1'b1;
         rspValid <= 1'b0;
         rspData  <= 16'h0000;
      end else begin
         rspValid <= 1'b0;
         case (state_q)
            H_IDLE: begin
               if (cmdValid) begin
                  cmdReady <= 1'b0;
                  kind_q   <= cmdKind;
                  ph_q     <= 5'h00;
                  if (cmdKind == swei_pkg::SWEI_CMD_STATUS) begin
                     sclk_q  <= 1'b0;
                     state_q <= H_STAT;
                  end else begin
                     selN_q   <= 1'b0;
                     bitCnt_q <= 6'h00;
                     tx_q     <= {opSel, cmdAddr, cmdData};
                     nBits_q  <= (cmdKind == swei_pkg::SWEI_CMD_WRITE_ENABLE ||
                                  cmdKind == swei_pkg::SWEI_CMD_WRITE_DISABLE) ?
                                 swei_pkg::FRAME_SHORT : swei_pkg::FRAME_LONG;
                     state_q  <= H_SHIFT;
                  end
               end
            end
            H_SHIFT: begin
               if (ph_q == 5'(HALF - 1)) begin
                  ph_q <= 5'h00;
                  if (sclk_q) begin
                     if (bitCnt_q == nBits_q) begin
                        selN_q  <= 1'b1;
                        din_q   <= 1'b0;
                        state_q <= H_GAP;
                     end else begin
                        sclk_q <= 1'b0;
                        din_q  <= tx_q[31];
                        tx_q   <= {tx_q[30:0], 1'b0};
                     end
                  end else begin
                     // Sample just before the rising edge, a half period after the change
                     sclk_q   <= 1'b1;
                     bitCnt_q <= bitCnt_q + 6'h01;
                     rx_q     <= {rx_q[14:0], doSync_q};
                  end
               end else begin
                  ph_q <= ph_q + 5'h01;
               end
            end
            H_STAT: begin
               ph_q <= ph_q + 5'h01;
               if (ph_q == 5'(HALF - 1)) begin
                  selN_q <= 1'b0;
               end else if (ph_q == 5'(3 * HALF - 1)) begin
                  rx_q    <= {15'h0000, doSync_q};
                  selN_q  <= 1'b1;
                  ph_q    <= 5'h00;
                  state_q <= H_GAP;
               end
            end
            H_GAP: begin
               if (ph_q == 5'(GAP - 1)) begin
                  sclk_q   <= 1'b1;
                  cmdReady <= 1'b1;
                  rspValid <= 1'b1;
                  if (kind_q == swei_pkg::SWEI_CMD_READ || kind_q == swei_pkg::SWEI_CMD_STATUS) begin
                     rspData <= rx_q;
                  end
                  state_q <= H_IDLE;
               end else begin
                  ph_q <= ph_q + 5'h01;
               end
            end
            default: state_q <= H_IDLE;
         endcase
      end
   end

endmodule

// ### bench/swei_link_assertions.sv
`timescale 1ns/1ps
module swei_link_assertions (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic selectN,
   input wire logic serialClkN,
   input wire logic serialIn,
   input wire logic serialOutEn,
   input wire logic writeProtect,
   input wire logic progBusy
);
   // Bench runs the device with a short programming time of 50 cycles
   localparam int BUSY_MAX = 80;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   property p_oe_needs_select;
      serialOutEn |-> !selectN;
   endproperty
   a_oe_needs_select: assert property (p_oe_needs_select)
      else $error("line driven while deselected");

   property p_instr_no_status;
      $fell(selectN) && serialClkN |-> !serialOutEn;
   endproperty
   a_instr_no_status: assert property (p_instr_no_status)
      else $error("line driven at instruction start");

   property p_status_on;
      $fell(selectN) && !serialClkN |-> ##[0:3] serialOutEn;
   endproperty
   a_status_on: assert property (p_status_on)
      else $error("status not driven after select with clock low");

   property p_oe_on_edge;
      $rose(serialOutEn) |-> $fell(serialClkN) || $fell(selectN);
   endproperty
   a_oe_on_edge: assert property (p_oe_on_edge)
      else $error("output enabled away from a falling clock or select");

   property p_din_stable;
      $rose(serialClkN) && !selectN |-> $stable(serialIn);
   endproperty
   a_din_stable: assert property (p_din_stable)
      else $error("data input moved at sampling edge");

   property p_desel_gap;
      $rose(selectN) |-> selectN [*5];
   endproperty
   a_desel_gap: assert property (p_desel_gap)
      else $error("select high time too short");

   property p_prog_bound;
      $rose(progBusy) |-> ##[1:BUSY_MAX] !progBusy;
   endproperty
   a_prog_bound: assert property (p_prog_bound)
      else $error("programming did not finish in time");

   property p_protect_abort;
      $rose(writeProtect) && progBusy |-> ##[1:8] !progBusy;
   endproperty
   a_protect_abort: assert property (p_protect_abort)
      else $error("protect did not abort programming");
endmodule

// ### bench/test_serial_word_eeprom_interface.sv
`timescale 1ns/1ps
module test_serial_word_eeprom_interface;
   // Starts high so reset rises on a falling edge and clears the link side
   logic                sys_clk   = 1'h1;
   logic                srst      = 1'h0;
   logic                cmdValid  = 1'h0;
   swei_pkg::swei_cmd_t cmdKind   = swei_pkg::SWEI_CMD_READ;
   logic [7:0]          cmdAddr   = 8'h00;
   logic [15:0]         cmdData   = 16'h0000;
   logic                protectIn = 1'h0;
   logic                cmdReady;
   logic                rspValid;
   logic                progBusy;
   logic [15:0]         rspData;
   logic [15:0]         rsp;
   logic [7:0]          addrs [3] = '{8'h00, 8'h7F, 8'hFF};
   int                  miscompares = 0;
   int                  checks = 0;
   int                  cycles = 0;

   always #25 sys_clk = ~sys_clk;

   swei_link_if lk ();

   swei_host i_swei_host (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .lk        (lk.host),
      .cmdValid  (cmdValid),
      .cmdKind   (cmdKind),
      .cmdAddr   (cmdAddr),
      .cmdData   (cmdData),
      .protectIn (protectIn),
      .cmdReady  (cmdReady),
      .rspValid  (rspValid),
      .rspData   (rspData)
   );

   // Short programming time keeps the run small
   swei_device #(.PROG_CYC(50)) i_swei_device (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .lk       (lk.device),
      .progBusy (progBusy)
   );

   swei_link_assertions i_swei_link_assertions (
      .sys_clk      (sys_clk),
      .srst         (srst),
      .selectN      (lk.selectN),
      .serialClkN   (lk.serialClkN),
      .serialIn     (lk.serialIn),
      .serialOutEn  (lk.serialOutEn),
      .writeProtect (lk.writeProtect),
      .progBusy     (progBusy)
   );

   task automatic stop_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %04h seen %04h", what, exp, got);
      end
   endtask

   // Response is sampled at the falling edge, where the pulse is settled
   task automatic issue(input swei_pkg::swei_cmd_t kind, input logic [7:0] addr,
                        input logic [15:0] data);
      int n;
      n = 0;
      @(negedge sys_clk);
      chk("cmdReady", 16'h0001, {15'h0000, cmdReady});
      cmdKind  = kind;
      cmdAddr  = addr;
      cmdData  = data;
      cmdValid = 1'h1;
      @(negedge sys_clk);
      cmdValid = 1'h0;
      chk("cmdReady", 16'h0000, {15'h0000, cmdReady});
      while (rspValid !== 1'h1 && n < 1000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 1000) begin
         miscompares++;
         $display("BAD response expected %0d seen %0d", 1, 0);
      end
      rsp = rspData;
   endtask

   task automatic status_is(input logic ready);
      issue(swei_pkg::SWEI_CMD_STATUS, 8'h00, 16'h0000);
      chk("status", {15'h0000, ready}, {15'h0000, rsp[0]});
   endtask

   task automatic wait_ready();
      int k;
      k = 0;
      rsp = 16'h0000;
      while (rsp[0] !== 1'h1 && k < 20) begin
         issue(swei_pkg::SWEI_CMD_STATUS, 8'h00, 16'h0000);
         k++;
      end
      chk("ready", 16'h0001, {15'h0000, rsp[0]});
   endtask

   // A refused write must leave the device ready at once
   task automatic wr(input logic [7:0] addr, input logic [15:0] data, input logic takes);
      issue(swei_pkg::SWEI_CMD_WRITE, addr, data);
      chk("progBusy", {15'h0000, takes}, {15'h0000, progBusy});
      status_is(!takes);
      wait_ready();
   endtask

   task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
      issue(swei_pkg::SWEI_CMD_READ, addr, 16'h0000);
      chk("read", exp, rsp);
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      @(negedge sys_clk);
      srst = 1'h1;
      repeat (12) @(negedge sys_clk);
      srst = 1'h0;
      issue(swei_pkg::SWEI_CMD_WRITE_ENABLE, 8'h5A, 16'h0000);
      wr(8'h10, 16'hA5A5, 1'h1);
      rd(8'h10, 16'hA5A5);
      issue(swei_pkg::SWEI_CMD_WRITE_DISABLE, 8'hC3, 16'h0000);
      wr(8'h10, 16'h1234, 1'h0);
      rd(8'h10, 16'hA5A5);
      // Second reset stands for power-up of the enable latch
      srst = 1'h1;
      repeat (12) @(negedge sys_clk);
      srst = 1'h0;
      wr(8'h10, 16'h5678, 1'h0);
      issue(swei_pkg::SWEI_CMD_WRITE_ENABLE, 8'h00, 16'h0000);
      protectIn = 1'h1;
      wr(8'h10, 16'h9999, 1'h0);
      rd(8'h10, 16'hA5A5);
      protectIn = 1'h0;
      foreach (addrs[i]) begin
         wr(addrs[i], {addrs[i], ~addrs[i]}, 1'h1);
      end
      foreach (addrs[i]) begin
         rd(addrs[i], {addrs[i], ~addrs[i]});
      end
      issue(swei_pkg::SWEI_CMD_WRITE, 8'h20, 16'h1111);
      protectIn = 1'h1;
      repeat (10) @(negedge sys_clk);
      status_is(1'h1);
      protectIn = 1'h0;
      rd(8'h20, swei_pkg::ERASED_WORD);
      stop_test();
   end
endmodule
